// File: design/card_uart_pkg.sv
`default_nettype none
package card_uart_pkg;

	// ------------------------------------------------------------
	// Register offsets on the external-data bus
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_STATUS  = 4'he;   // Status, read only
	localparam logic [3:0] ADDR_DIVIDER = 4'h2;   // ETU divider reload value
	localparam logic [3:0] ADDR_CONFIG2 = 4'h3;   // Second configuration register
	localparam logic [3:0] ADDR_FIFOCTL = 4'hc;   // Allowed errors and FIFO depth

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_TO3   = 7;                 // Time-out three
	localparam int BIT_TO2   = 6;                 // Time-out two
	localparam int BIT_TO1   = 5;                 // Time-out one
	localparam int BIT_EA    = 4;                 // Early answer
	localparam int BIT_PE    = 3;                 // Parity error
	localparam int BIT_OVR   = 2;                 // Overrun
	localparam int BIT_FER   = 1;                 // Framing error
	localparam int BIT_BUF   = 0;                 // Transmit empty / receive full
	localparam int BIT_MASK  = 6;                 // Buffer flag interrupt mask in config two
	localparam int PEC_LSB   = 4;                 // Allowed parity errors, bits 6..4
	localparam int FL_LSB    = 0;                 // FIFO length, bits 2..0

	// ------------------------------------------------------------
	// Values after reset
	// ------------------------------------------------------------
	localparam logic [7:0] RST_STATUS  = 8'h00;
	localparam logic [7:0] RST_DIVIDER = 8'h00;
	localparam logic [7:0] RST_CONFIG2 = 8'h00;
	localparam logic [7:0] RST_FIFOCTL = 8'h00;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS       = 25;                          // 40 MHz system clock
	localparam int READ_CLEAR_NS       = 2000;                        // Flag clear after status read
	localparam int READ_CLEAR_CYC      = READ_CLEAR_NS / CLK_PERIOD_NS;
	localparam int EA_LOW_IGNORE_CLKS  = 200;                         // Card clocks ignored, reset low
	localparam logic [3:0] FER_ETU     = 4'ha;                        // Framing check at 10.25 ETU
	localparam logic [3:0] RX_PE_ETU   = 4'ha;                        // Receive parity at 10.5 ETU
	localparam logic [3:0] TX_PE_ETU   = 4'hb;                        // Transmit parity at 11.5 ETU

	// ------------------------------------------------------------
	// Events from the character engine
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] timeout_hit;     // Terminal count pulses, bit 0 is counter one
		logic       start_bit;       // Start bit seen on the card line
		logic       parity_bad;      // Parity of current character wrong, level
		logic       tx_nak;          // Card refused current sent character, level
		logic       tx_ready;        // Transmit register may take a character
		logic       tx_reg_written;  // Transmit register was loaded
	} uart_evt_t;

	// Character timer states
	typedef enum logic {
		CHAR_IDLE,
		CHAR_TIMING
	} char_state_t;

endpackage
`default_nettype wire

// File: design/etu_divider.sv
`timescale 1ns/100ps
`default_nettype none
module etu_divider #(
	parameter int WIDTH = 8
) (
	input  wire logic             clock,
	input  wire logic             sys_rst,
	input  wire logic             ce,
	input  wire logic             restart,
	input  wire logic             card_tick,
	input  wire logic [WIDTH-1:0] reload_value,
	output logic                  etu_tick,
	output logic                  half_tick,
	output logic                  quarter_tick
);

	// ------------------------------------------------------------
	// Down counter with automatic reload
	// ------------------------------------------------------------
	logic [WIDTH-1:0] count;        // Current count
	logic [WIDTH-1:0] next_count;   // Next count

	// A value of zero or one gives one card clock per ETU rather than a stall
	always_comb begin
		next_count   = count;
		etu_tick     = 1'b0;
		half_tick    = 1'b0;
		quarter_tick = 1'b0;
		if (restart) begin
			next_count = reload_value;
		end else if (card_tick) begin
			if (count <= WIDTH'(1)) begin
				next_count = reload_value;
				etu_tick   = 1'b1;
			end else begin
				next_count = count - WIDTH'(1);
			end
			// Fraction points; coarse for small reload values
			half_tick    = !etu_tick && (next_count == (reload_value >> 1));
			quarter_tick = !etu_tick && (next_count == reload_value - (reload_value >> 2));
		end
	end

	// Register only
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			count <= '0;
		end else if (ce) begin
			count <= next_count;
		end
	end

endmodule
`default_nettype wire

// File: design/card_uart_status.sv
// Behaviour
// - Time-out flags set at terminal count
// - Early answer flag from reset-phase clock windows
// - Restart early-answer windows on reset change
// - T0 receive: flag after allowed bad characters
// - T0 transmit: flag after allowed card refusals
// - Parity flag at 10.5 or 11.5 ETU
// - T0: drop bad character, card repeats
// - T1: store bad characters, counter idle
// - Overrun when character arrives, buffer full
// - Framing error if line low at 10.25
// - Status read clears framing error
// - Bit 0 means empty or full by mode
// - Transmit empty set when next load allowed
// - Transmit empty cleared by write or mode
// - Receive full at depth, clears when level drops
// - Eight-bit auto-reload ETU down counter
// - Interrupt low while any error flag set
// - Read clears causing flags after 2 us
// - Error field 000 one, 111 eight
// - Buffer flag interrupts only when unmasked
`timescale 1ns/100ps
`default_nettype none
module card_uart_status #(
	parameter int NMAX     = 384,   // Early-answer window with reset high, in card clocks
	parameter int DIV_BITS = 8      // ETU divider width
) (
	input  wire logic                  clock,
	input  wire logic                  sys_rst,
	input  wire logic                  ce,
	input  wire logic [3:0]            bus_addr,
	input  wire logic [7:0]            bus_wdata,
	input  wire logic                  bus_rd,
	input  wire logic                  bus_wr,
	output logic      [7:0]            bus_rdata,
	input  wire card_uart_pkg::uart_evt_t evt,
	input  wire logic                  tx_mode,
	input  wire logic                  protocol_t1,
	input  wire logic                  card_rst,
	input  wire logic                  card_io,
	input  wire logic                  card_tick,
	input  wire logic [3:0]            rx_fifo_level,
	output logic                       rx_store,
	output logic                       tx_retransmit,
	output logic                       uart_interrupt_out_n
);

	// ------------------------------------------------------------
	// Constants local to this file
	// ------------------------------------------------------------
	localparam int CLR_WIN = card_uart_pkg::READ_CLEAR_CYC;   // Clear delay after status read

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [7:0] divider, next_divider;     // ETU divider reload value
	logic [7:0] config_two, next_config_two; // Mask lives here
	logic [7:0] fifo_ctl, next_fifo_ctl;   // Allowed errors and depth
	logic [7:0] next_rdata;                // Read data before the flop
	logic [7:0] status;                    // Assembled status byte
	logic       status_read;               // Status read strobe this cycle

	assign status_read = bus_rd && (bus_addr == card_uart_pkg::ADDR_STATUS);

	// Decode writes and reads; unmapped and FIFO-control reads give zero
	always_comb begin
		next_divider    = divider;
		next_config_two = config_two;
		next_fifo_ctl   = fifo_ctl;
		next_rdata      = bus_rdata;
		if (bus_wr) begin
			case (bus_addr)
				card_uart_pkg::ADDR_DIVIDER: next_divider    = bus_wdata;
				card_uart_pkg::ADDR_CONFIG2: next_config_two = bus_wdata;
				card_uart_pkg::ADDR_FIFOCTL: next_fifo_ctl   = bus_wdata & 8'h77;
				default:                     next_divider    = divider;
			endcase
		end
		if (bus_rd) begin
			case (bus_addr)
				card_uart_pkg::ADDR_STATUS:  next_rdata = status;
				card_uart_pkg::ADDR_DIVIDER: next_rdata = divider;
				card_uart_pkg::ADDR_CONFIG2: next_rdata = config_two;
				default:                     next_rdata = 8'h00;
			endcase
		end
	end

	// Register only
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			divider    <= card_uart_pkg::RST_DIVIDER;
			config_two <= card_uart_pkg::RST_CONFIG2;
			fifo_ctl   <= card_uart_pkg::RST_FIFOCTL;
			bus_rdata  <= 8'h00;
		end else if (ce) begin
			divider    <= next_divider;
			config_two <= next_config_two;
			fifo_ctl   <= next_fifo_ctl;
			bus_rdata  <= next_rdata;
		end
	end

	// ------------------------------------------------------------
	// ETU divider and character timer
	// ------------------------------------------------------------
	logic        etu_tick, half_tick, quarter_tick;
	card_uart_pkg::char_state_t cstate, next_cstate;   // Timer state
	logic [3:0]  etu_cnt, next_etu_cnt;  // Whole ETUs since start bit
	logic        fer_point;              // 10.25 ETU
	logic        rx_point;               // 10.5 ETU
	logic        tx_point;               // 11.5 ETU

	etu_divider #(
		.WIDTH (DIV_BITS)
	) u_div (
		.clock        (clock),
		.sys_rst      (sys_rst),
		.ce           (ce),
		.restart      (evt.start_bit),
		.card_tick    (card_tick),
		.reload_value (divider),
		.etu_tick     (etu_tick),
		.half_tick    (half_tick),
		.quarter_tick (quarter_tick)
	);

	assign fer_point = (cstate == card_uart_pkg::CHAR_TIMING) && quarter_tick
	                   && (etu_cnt == card_uart_pkg::FER_ETU);
	assign rx_point  = (cstate == card_uart_pkg::CHAR_TIMING) && half_tick && !tx_mode
	                   && (etu_cnt == card_uart_pkg::RX_PE_ETU);
	assign tx_point  = (cstate == card_uart_pkg::CHAR_TIMING) && half_tick && tx_mode
	                   && (etu_cnt == card_uart_pkg::TX_PE_ETU);

	// Count ETUs from each start bit; stop after the last decision point
	always_comb begin
		next_cstate  = cstate;
		next_etu_cnt = etu_cnt;
		case (cstate)
			card_uart_pkg::CHAR_IDLE: begin
				next_etu_cnt = 4'h0;
			end
			card_uart_pkg::CHAR_TIMING: begin
				if (etu_tick) begin
					next_etu_cnt = etu_cnt + 4'h1;
				end
				if (rx_point || tx_point) begin
					next_cstate = card_uart_pkg::CHAR_IDLE;
				end
			end
			default: next_cstate = card_uart_pkg::CHAR_IDLE;
		endcase
		if (evt.start_bit) begin
			next_cstate  = card_uart_pkg::CHAR_TIMING;
			next_etu_cnt = 4'h0;
		end
	end

	// Register only
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cstate  <= card_uart_pkg::CHAR_IDLE;
			etu_cnt <= 4'h0;
		end else if (ce) begin
			cstate  <= next_cstate;
			etu_cnt <= next_etu_cnt;
		end
	end

	// ------------------------------------------------------------
	// Parity error counting and character acceptance
	// ------------------------------------------------------------
	logic [2:0] pec;                 // Allowed errors minus one
	logic [2:0] err_cnt, next_err_cnt; // Errors seen so far
	logic       err_hit;            // Programmed number reached
	logic       pe_set;             // Parity flag set event

	assign pec     = fifo_ctl[card_uart_pkg::PEC_LSB +: 3];
	assign err_hit = (err_cnt == pec);

	// T1 bypasses the counter entirely; a good character resets it
	always_comb begin
		next_err_cnt  = err_cnt;
		pe_set        = 1'b0;
		rx_store      = 1'b0;
		tx_retransmit = 1'b0;
		if (rx_point) begin
			if (protocol_t1) begin
				rx_store = 1'b1;
				pe_set   = evt.parity_bad;
			end else if (!evt.parity_bad) begin
				rx_store     = 1'b1;
				next_err_cnt = 3'h0;
			end else if (err_hit) begin
				pe_set       = 1'b1;
				next_err_cnt = 3'h0;
			end else begin
				next_err_cnt = err_cnt + 3'h1;
			end
		end
		if (tx_point && !protocol_t1) begin
			if (!evt.tx_nak) begin
				next_err_cnt = 3'h0;
			end else if (err_hit) begin
				pe_set       = 1'b1;
				next_err_cnt = 3'h0;
			end else begin
				next_err_cnt  = err_cnt + 3'h1;
				tx_retransmit = 1'b1;
			end
		end
	end

	// Register only
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			err_cnt <= 3'h0;
		end else if (ce) begin
			err_cnt <= next_err_cnt;
		end
	end

	// ------------------------------------------------------------
	// Early-answer windows
	// ------------------------------------------------------------
	logic [9:0] rst_clks, next_rst_clks;   // Card clocks since reset line changed
	logic       rst_prev, next_rst_prev;   // Reset line one cycle ago
	logic       first_seen, next_first_seen; // First start bit already judged
	logic       ea_set;                    // Early answer event

	// Counter saturates so long reset phases do not wrap into the window
	always_comb begin
		next_rst_prev   = card_rst;
		next_rst_clks   = rst_clks;
		next_first_seen = first_seen;
		ea_set          = 1'b0;
		if (card_tick && (rst_clks != 10'h3ff)) begin
			next_rst_clks = rst_clks + 10'h001;
		end
		if (evt.start_bit && !first_seen) begin
			if (!card_rst && (rst_clks >= 10'(card_uart_pkg::EA_LOW_IGNORE_CLKS))) begin
				ea_set          = 1'b1;
				next_first_seen = 1'b1;
			end else if (card_rst && (rst_clks < 10'(NMAX))) begin
				ea_set          = 1'b1;
				next_first_seen = 1'b1;
			end else if (card_rst) begin
				next_first_seen = 1'b1;
			end
		end
		if (card_rst != rst_prev) begin
			next_rst_clks   = 10'h000;
			next_first_seen = 1'b0;
		end
	end

	// Register only
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rst_clks   <= 10'h000;
			rst_prev   <= 1'b0;
			first_seen <= 1'b0;
		end else if (ce) begin
			rst_clks   <= next_rst_clks;
			rst_prev   <= next_rst_prev;
			first_seen <= next_first_seen;
		end
	end

	// ------------------------------------------------------------
	// Sticky flags and delayed read clear
	// ------------------------------------------------------------
	logic [7:1] flags, next_flags;     // Bits 7..1 of the status byte
	logic [7:1] set_vec;               // Set events this cycle
	logic [7:1] snap, next_snap;       // Flags seen by the pending read
	logic [6:0] clr_cnt, next_clr_cnt; // Cycles until the clear lands
	logic       clr_pulse;             // Clear lands this cycle
	logic       tx_empty_flag, next_tbe;         // Transmit empty
	logic       rx_full_flag;                   // Receive full
	logic       fifo_full;             // Level at programmed depth

	assign fifo_full = (rx_fifo_level >= ({1'b0, fifo_ctl[card_uart_pkg::FL_LSB +: 3]} + 4'h1));
	assign rx_full_flag       = fifo_full;
	assign clr_pulse = (clr_cnt == 7'h01);

	always_comb begin
		set_vec                       = '0;
		set_vec[card_uart_pkg::BIT_TO3] = evt.timeout_hit[2];
		set_vec[card_uart_pkg::BIT_TO2] = evt.timeout_hit[1];
		set_vec[card_uart_pkg::BIT_TO1] = evt.timeout_hit[0];
		set_vec[card_uart_pkg::BIT_EA]  = ea_set;
		set_vec[card_uart_pkg::BIT_PE]  = pe_set;
		set_vec[card_uart_pkg::BIT_OVR] = rx_store && fifo_full;
		set_vec[card_uart_pkg::BIT_FER] = fer_point && !card_io;
	end

	// A read snapshots the flags; only those are cleared, and a new set wins
	always_comb begin
		next_snap    = snap;
		next_clr_cnt = clr_cnt;
		next_flags   = flags;
		if (clr_cnt != 7'h00) begin
			next_clr_cnt = clr_cnt - 7'h01;
		end
		if (clr_pulse) begin
			next_flags = flags & ~snap;
		end
		if (status_read) begin
			next_snap    = flags;
			next_clr_cnt = 7'(CLR_WIN);
		end
		next_flags = next_flags | set_vec;
	end

	// Transmit empty: a write or a mode change beats a ready in the same cycle
	always_comb begin
		next_tbe = tx_empty_flag;
		if (tx_mode && evt.tx_ready) begin
			next_tbe = 1'b1;
		end
		if (evt.tx_reg_written || !tx_mode) begin
			next_tbe = 1'b0;
		end
	end

	// Register only
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			flags   <= card_uart_pkg::RST_STATUS[7:1];
			snap    <= '0;
			clr_cnt <= 7'h00;
			tx_empty_flag     <= card_uart_pkg::RST_STATUS[0];
		end else if (ce) begin
			flags   <= next_flags;
			snap    <= next_snap;
			clr_cnt <= next_clr_cnt;
			tx_empty_flag     <= next_tbe;
		end
	end

	// Shared bit follows the mode; never touched by a status read
	assign status = {flags, tx_mode ? tx_empty_flag : rx_full_flag};

	// ------------------------------------------------------------
	// Interrupt
	// ------------------------------------------------------------
	assign uart_interrupt_out_n = !((|flags)
	                               || (status[card_uart_pkg::BIT_BUF]
	                                   && !config_two[card_uart_pkg::BIT_MASK]));

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst || !ce);

	sequence s_status_read;
		status_read;
	endsequence

	sequence s_clear_lands;
		##[1:CLR_WIN] clr_pulse;
	endsequence

	AST_TIMEOUT_SET: assert property (evt.timeout_hit[0] |=> flags[card_uart_pkg::BIT_TO1])
		else $error("time-out one not flagged");
	AST_EA_RESTART: assert property ((card_rst != rst_prev) |=> (rst_clks <= 10'h001) && !first_seen)
		else $error("early-answer window not restarted");
	AST_EA_IGNORE: assert property (evt.start_bit && !card_rst && (card_rst == rst_prev)
		&& (rst_clks < 10'(card_uart_pkg::EA_LOW_IGNORE_CLKS)) |-> !ea_set)
		else $error("early start bit counted");
	AST_PE_RX: assert property (rx_point && !protocol_t1 && evt.parity_bad && err_hit
		|=> flags[card_uart_pkg::BIT_PE])
		else $error("receive parity flag missing");
	AST_T0_DROP: assert property (rx_point && !protocol_t1 && evt.parity_bad |-> !rx_store)
		else $error("bad character stored in T0");
	AST_T1_KEEP: assert property (rx_point && protocol_t1 |-> rx_store && (next_err_cnt == err_cnt))
		else $error("T1 character not stored");
	AST_OVR: assert property (rx_store && fifo_full |=> flags[card_uart_pkg::BIT_OVR])
		else $error("overrun not flagged");
	AST_FER: assert property (fer_point && !card_io |=> flags[card_uart_pkg::BIT_FER])
		else $error("framing error not flagged");
	AST_READ_CLEAR: assert property (s_status_read |-> s_clear_lands)
		else $error("read clear did not land");
	AST_FER_CLEAR: assert property (clr_pulse && snap[card_uart_pkg::BIT_FER]
		&& !set_vec[card_uart_pkg::BIT_FER] |=> !flags[card_uart_pkg::BIT_FER])
		else $error("framing error survived read");
	AST_TBE_CLR: assert property (evt.tx_reg_written |=> !tx_empty_flag)
		else $error("transmit empty not cleared");
	AST_IRQ: assert property (flags[card_uart_pkg::BIT_PE] |-> !uart_interrupt_out_n)
		else $error("interrupt not asserted");

endmodule
`default_nettype wire

// File: verification/card_model.sv
`timescale 1ns/100ps
`default_nettype none
// --------------------------------------------
// Smart card on the I/O line
// --------------------------------------------
module card_model (
	output logic card_tick,
	output logic card_rst,
	output logic card_io,
	output logic start_bit,
	output logic parity_bad,
	output logic tx_nak,
	input  wire logic clock
);
	// Card clock runs free while the card is powered
	initial card_tick = 1'b0;
	always @(negedge clock) card_tick <= ~card_tick;
	// Line released (high) and no event between frames
	initial begin
		card_rst = 1'b0;
		card_io = 1'b1;
		start_bit = 1'b0;
		parity_bad = 1'b0;
		tx_nak = 1'b0;
	end
	// Move the card reset line
	task automatic set_rst(input logic v);
		@(negedge clock);
		card_rst = v;
	endtask
	// One frame of 8 clocks per ETU; io_low holds the line past the stop point
	task automatic frame(input logic bad, input logic nak, input logic io_low);
		@(negedge clock);
		card_io = 1'b0;
		start_bit = 1'b1;
		parity_bad = bad;
		tx_nak = nak;
		@(negedge clock);
		start_bit = 1'b0;
		repeat (75) @(negedge clock);
		card_io = io_low ? 1'b0 : 1'b1;
		repeat (30) @(negedge clock);
		// Released: the card does not keep stale levels
		card_io = 1'b1;
		parity_bad = 1'b0;
		tx_nak = 1'b0;
	endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
// --------------------------------------------
// Status block bench
// --------------------------------------------
module tb;
	logic clock, sys_rst, ce, bus_rd, bus_wr, tx_mode, protocol_t1;
	logic [3:0] bus_addr, rx_fifo_level;
	logic [7:0] bus_wdata, bus_rdata;
	logic [2:0] to_hit;   // Time-out terminal pulses
	logic trdy, twr;      // Transmit register events
	wire logic ctk, crst, cio, sb, pb, nk, rx_store, tx_retransmit, irq_n;
	card_uart_pkg::uart_evt_t evt;
	int num_errors = 0, n_compared = 0, cycles = 0, stores = 0, retx = 0;
	assign evt = {to_hit, sb, pb, nk, trdy, twr};
	card_model card (.card_tick(ctk), .card_rst(crst), .card_io(cio), .start_bit(sb),
		.parity_bad(pb), .tx_nak(nk), .clock(clock));
	card_uart_status DUT (.clock(clock), .sys_rst(sys_rst), .ce(ce), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_rdata(bus_rdata),
		.evt(evt), .tx_mode(tx_mode), .protocol_t1(protocol_t1), .card_rst(crst),
		.card_io(cio), .card_tick(ctk), .rx_fifo_level(rx_fifo_level), .rx_store(rx_store),
		.tx_retransmit(tx_retransmit), .uart_interrupt_out_n(irq_n));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// Pulse counters and hang guard; a hang costs one mismatch
	always @(posedge clock) begin
		cycles++;
		stores += rx_store;
		retx += tx_retransmit;
		if (cycles == 20000) begin
			num_errors++;
			end_of_test();
		end
	end
	// --------------------------------------------
	// Shared tasks
	// --------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask
	// One-cycle strobe; rdata is looked at once it has settled
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(negedge clock);
		bus_addr = a;
		bus_wdata = d;
		bus_rd = ~w;
		bus_wr = w;
		@(negedge clock);
		bus_rd = 1'b0;
		bus_wr = 1'b0;
		@(negedge clock);
	endtask
	// Status read, then let the delayed read clear land
	task automatic st(input logic [7:0] exp, input logic irq);
		bus(1'b0, card_uart_pkg::ADDR_STATUS, 8'h00);
		chk(bus_rdata, exp);
		chk({7'h00, irq_n}, {7'h00, irq});
		repeat (card_uart_pkg::READ_CLEAR_CYC + 4) @(negedge clock);
	endtask
	// --------------------------------------------
	// Scenarios
	// --------------------------------------------
	task automatic t_regs();
		st(8'h00, 1'b1);
		bus(1'b1, card_uart_pkg::ADDR_STATUS, 8'hff);
		st(8'h00, 1'b1);
		bus(1'b0, 4'h0, 8'h00);
		chk(bus_rdata, 8'h00);
		bus(1'b1, card_uart_pkg::ADDR_DIVIDER, 8'h04);
		bus(1'b0, card_uart_pkg::ADDR_DIVIDER, 8'h00);
		chk(bus_rdata, 8'h04);
		bus(1'b1, card_uart_pkg::ADDR_FIFOCTL, 8'h10);
	endtask
	task automatic t_early();
		card.set_rst(1'b1);
		card.frame(1'b0, 1'b0, 1'b0);
		st(8'h10, 1'b0);
		st(8'h00, 1'b1);
		// Reset low: start bits inside the first 200 card clocks are ignored
		card.set_rst(1'b0);
		card.frame(1'b0, 1'b0, 1'b0);
		st(8'h00, 1'b1);
		repeat (300) @(negedge clock);
		card.frame(1'b0, 1'b0, 1'b0);
		st(8'h10, 1'b0);
		st(8'h00, 1'b1);
	endtask
	task automatic t_timeout();
		for (int i = 0; i < 3; i++) begin
			@(negedge clock);
			to_hit = 3'(1 << i);
			@(negedge clock);
			to_hit = 3'b000;
			st(8'h20 << i, 1'b0);
			st(8'h00, 1'b1);
		end
		// Frozen state ignores events while the enable is low
		@(negedge clock);
		ce = 1'b0;
		to_hit = 3'b111;
		@(negedge clock);
		to_hit = 3'b000;
		ce = 1'b1;
		st(8'h00, 1'b1);
	endtask
	task automatic t_frame_err();
		card.frame(1'b0, 1'b0, 1'b1);
		st(8'h02, 1'b0);
		st(8'h00, 1'b1);
	endtask
	task automatic t_t0_rx();
		stores = 0;
		card.frame(1'b1, 1'b0, 1'b0);
		st(8'h00, 1'b1);
		card.frame(1'b1, 1'b0, 1'b0);
		st(8'h08, 1'b0);
		chk(8'(stores), 8'h00);
		st(8'h00, 1'b1);
	endtask
	task automatic t_t1_rx();
		protocol_t1 = 1'b1;
		stores = 0;
		card.frame(1'b1, 1'b0, 1'b0);
		chk(8'(stores), 8'h01);
		st(8'h08, 1'b0);
		rx_fifo_level = 4'h1;
		card.frame(1'b0, 1'b0, 1'b0);
		st(8'h05, 1'b0);
		bus(1'b1, card_uart_pkg::ADDR_CONFIG2, 8'h40);
		st(8'h01, 1'b1);
		bus(1'b1, card_uart_pkg::ADDR_CONFIG2, 8'h00);
		st(8'h01, 1'b0);
		rx_fifo_level = 4'h0;
		st(8'h00, 1'b1);
	endtask
	task automatic t_tx();
		protocol_t1 = 1'b0;
		tx_mode = 1'b1;
		for (int i = 0; i < 2; i++) begin
			@(negedge clock);
			trdy = 1'b1;
			@(negedge clock);
			trdy = 1'b0;
			st(8'h01, 1'b0);
			st(8'h01, 1'b0);
			if (i == 0) twr = 1'b1;
			else tx_mode = 1'b0;
			@(negedge clock);
			twr = 1'b0;
			st(8'h00, 1'b1);
			tx_mode = 1'b1;
		end
		retx = 0;
		card.frame(1'b0, 1'b1, 1'b0);
		st(8'h00, 1'b1);
		card.frame(1'b0, 1'b1, 1'b0);
		st(8'h08, 1'b0);
		chk(8'(retx), 8'h01);
		// Manual rewrite only after the 13.5 ETU pause, already spent by the read
		@(negedge clock);
		twr = 1'b1;
		@(negedge clock);
		twr = 1'b0;
	endtask
	// Closing report
	task automatic end_of_test();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		{sys_rst, ce, bus_rd, bus_wr, tx_mode, protocol_t1, trdy, twr} = 8'hc0;
		{bus_addr, rx_fifo_level, bus_wdata, to_hit} = '0;
		repeat (10) @(negedge clock);
		sys_rst = 1'b0;
		t_regs();
		t_early();
		t_timeout();
		t_frame_err();
		t_t0_rx();
		t_t1_rx();
		t_tx();
		end_of_test();
	end
endmodule
`default_nettype wire
